// ==== design/pdt_timer.sv ====
// Purpose: 8-bit down-counter with 7-bit prescaler and zero flag
// Assumes: clk is the internal clock; bus strobes are one cycle wide
// Notes:   all edges are detected synchronously on clk
`timescale 1ns/1ps

// Summary of operation
// - 8-bit counter fed by 7-bit prescaler
// - count register read/write at 0D3h
// - prescaler state readable at 0D2h
// - count decrements on selected tap rising edge
// - decrement to zero sets zero flag
// - zero flag with enable requests vector 3
// - timer request can wake from wait
// - prescaler clocked by internal clock divided 12
// - tap 0 uses prescaler input, then bits
// - run clear forces prescaler ones, halts count
// - prescaler writable while run is set
// - writing 00h or bit7 one sets flag
// - reset: count FFh, prescaler 7Fh, control cleared
// - count write beats coincident decrement to zero
// - reads return live count and prescaler
// - control/status at 0D4h with listed fields
// - control bit 4 enables the timer
// - tap select is power-of-two divide 1..128
module pdt_timer (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [7:0] busAddr,
   input  wire logic       busWrite,
   input  wire logic       busRead,
   input  wire logic [7:0] busWdata,
   output logic      [7:0] busRdata,
   output logic            timerIrq,
   output logic      [1:0] timerIrqVector,
   output logic            wakeRequest
);

   // ****************************************
   // state
   // ****************************************
   logic [7:0] count_r;
   logic [6:0] prescaler_r;
   logic [7:0] control_r;
   logic [3:0] divCount_r;
   logic       tapLevel_r;
   logic [2:0] tapSel_r;
   logic [7:0] busRdata_r;

   logic       psIn;
   logic       psInRise;
   logic       tapLevel;
   logic       tapRise;
   logic       countTick;
   logic       wrCount;
   logic       wrPrescaler;
   logic       wrControl;
   logic       psRun;

   function automatic logic selectTap(input logic [2:0] tap, input logic psInLvl, input logic [6:0] ps);
      if (tap == 3'h0) begin
         selectTap = psInLvl;
      end else begin
         selectTap = ps[tap - 3'h1];
      end
   endfunction

   assign wrCount     = busWrite && (busAddr == pdt_pkg::ADDR_COUNT);
   assign wrPrescaler = busWrite && (busAddr == pdt_pkg::ADDR_PRESCALER);
   assign wrControl   = busWrite && (busAddr == pdt_pkg::ADDR_CONTROL);
   assign psRun       = control_r[pdt_pkg::BIT_PSC_RUN];

   // ****************************************
   // divide by twelve
   // ****************************************
   // square wave at clk/12; rise marks the prescaler step
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         divCount_r <= 4'h0;
      end else if (divCount_r == pdt_pkg::DIV_LAST) begin
         divCount_r <= 4'h0;
      end else begin
         divCount_r <= divCount_r + 4'h1;
      end
   end

   assign psIn     = (divCount_r >= pdt_pkg::DIV_HALF);
   assign psInRise = (divCount_r == pdt_pkg::DIV_HALF);

   // ****************************************
   // prescaler
   // ****************************************
   // a write while stopped is dropped: the bits are held at all ones
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prescaler_r <= pdt_pkg::RESET_PRESCALER;
      end else if (!psRun) begin
         prescaler_r <= pdt_pkg::RESET_PRESCALER;
      end else if (wrPrescaler) begin
         prescaler_r <= busWdata[6:0];
      end else if (psInRise) begin
         prescaler_r <= prescaler_r - 7'h1;
      end
   end

   // ****************************************
   // tap edge detect
   // ****************************************
   assign tapLevel = selectTap(control_r[pdt_pkg::TAP_MSB:0], psIn, prescaler_r);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tapLevel_r <= 1'b1;
      end else begin
         tapLevel_r <= tapLevel;
      end
   end

   // a tap change swaps mux inputs; that step is not a prescaler edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tapSel_r <= 3'h0;
      end else begin
         tapSel_r <= control_r[pdt_pkg::TAP_MSB:0];
      end
   end

   assign tapRise   = tapLevel && !tapLevel_r
                      && (tapSel_r == control_r[pdt_pkg::TAP_MSB:0]);
   assign countTick = tapRise && psRun && control_r[pdt_pkg::BIT_CNT_EN];

   // ****************************************
   // counter
   // ****************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_r <= pdt_pkg::RESET_COUNT;
      end else if (wrCount) begin
         count_r <= busWdata;
      end else if (countTick) begin
         count_r <= count_r - 8'h1;
      end
   end

   // ****************************************
   // control/status
   // ****************************************
   // hardware set beats a software clear of the zero flag
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         control_r <= pdt_pkg::RESET_CONTROL;
      end else begin
         if (wrControl) begin
            control_r <= busWdata;
            control_r[pdt_pkg::BIT_RESERVED] <= 1'b0;
         end
         if (countTick && !wrCount && (count_r == 8'h01)) begin
            control_r[pdt_pkg::BIT_ZERO] <= 1'b1;
         end
         if (wrCount && (busWdata == pdt_pkg::COUNT_ZERO)) begin
            control_r[pdt_pkg::BIT_ZERO] <= 1'b1;
         end
      end
   end

   // ****************************************
   // read port
   // ****************************************
   // live values, no latching, so reads need not stop the timer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busRdata_r <= 8'h00;
      end else if (busRead) begin
         case (busAddr)
            pdt_pkg::ADDR_PRESCALER: busRdata_r <= {1'b0, prescaler_r};
            pdt_pkg::ADDR_COUNT:     busRdata_r <= count_r;
            pdt_pkg::ADDR_CONTROL:   busRdata_r <= control_r;
            default:                 busRdata_r <= 8'h00;
         endcase
      end
   end

   assign busRdata = busRdata_r;

   // ****************************************
   // interrupt request
   // ****************************************
   // level request: stays up until software clears the flag or the interrupt enable
   assign timerIrq       = control_r[pdt_pkg::BIT_ZERO] && control_r[pdt_pkg::BIT_IRQ_EN];
   assign timerIrqVector = pdt_pkg::TIMER_IRQ_VECTOR;
   assign wakeRequest    = timerIrq;

endmodule

// ==== design/pdt_pkg.sv ====
// Purpose: constants for the prescaled down-counter timer
// Assumes: byte-wide data-space register port, 8-bit addresses
// Notes:   offsets are data-space byte addresses
package pdt_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] ADDR_PRESCALER   = 8'hd2;
   localparam logic [7:0] ADDR_COUNT       = 8'hd3;
   localparam logic [7:0] ADDR_CONTROL     = 8'hd4;
   // ****************************************
   // control/status fields
   // ****************************************
   localparam int         BIT_ZERO         = 7;
   localparam int         BIT_IRQ_EN       = 6;
   localparam int         BIT_RESERVED     = 5;
   localparam int         BIT_CNT_EN       = 4;
   localparam int         BIT_PSC_RUN      = 3;
   localparam int         TAP_MSB          = 2;
   // ****************************************
   // reset values and timing
   // ****************************************
   localparam logic [7:0] RESET_COUNT      = 8'hff;
   localparam logic [6:0] RESET_PRESCALER  = 7'h7f;
   localparam logic [7:0] RESET_CONTROL    = 8'h00;
   localparam logic [7:0] COUNT_ZERO       = 8'h00;
   localparam int         INT_CLK_DIVIDE   = 12;
   localparam logic [3:0] DIV_LAST         = 4'(INT_CLK_DIVIDE - 1);
   localparam logic [3:0] DIV_HALF         = 4'(INT_CLK_DIVIDE / 2);
   localparam logic [1:0] TIMER_IRQ_VECTOR = 2'h3;
endpackage

// ==== verification/pdt_timer_monitor.sv ====
// Purpose: port checks for pdt_timer
// Assumes: one clock, nrst async low
// Notes:   bind at foot of file
`timescale 1ns/1ps
module pdt_timer_monitor (
   input wire logic       clk, nrst, busWrite, busRead, timerIrq, wakeRequest,
   input wire logic [7:0] busAddr, busWdata, busRdata,
   input wire logic [1:0] timerIrqVector);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_irq_vector: assert property (timerIrqVector == 2'h3) else $error("vector");
   chk_wake_irq: assert property (wakeRequest == timerIrq) else $error("wake");
   chk_unmapped_read: assert property (busRead && busAddr < 8'hd2 |=> busRdata == 8'h00) else $error("map");
   chk_psc_msb: assert property (busRead && busAddr == 8'hd2 |=> !busRdata[7]) else $error("psc");
   chk_irq_flags: assert property (busRead && busAddr == 8'hd4
      |=> (busRdata[7] & busRdata[6]) == $past(timerIrq)) else $error("irq");
   chk_zero_write: assert property (busWrite && busAddr == 8'hd3 && busWdata == 8'h00
      ##1 busRead && !busWrite && busAddr == 8'hd4 |=> busRdata[7]) else $error("flag");
   chk_ctrl_back: assert property (busWrite && busAddr == 8'hd4 ##1 busRead && !busWrite && busAddr == 8'hd4
      |=> (busRdata & 8'h7f) == ($past(busWdata, 2) & 8'h5f)) else $error("ctrl");
   chk_count_back: assert property (busWrite && busAddr == 8'hd3 ##1 busRead && !busWrite && busAddr == 8'hd3
      |=> busRdata == $past(busWdata, 2) || busRdata == $past(busWdata, 2) - 8'h01) else $error("count");
   cover property ($rose(timerIrq));
   cover property ($fell(timerIrq));
   cover property (busWrite && busAddr == 8'hd2);
endmodule
bind pdt_timer pdt_timer_monitor u_mon (.clk(clk), .nrst(nrst), .busWrite(busWrite), .busRead(busRead),
   .timerIrq(timerIrq), .wakeRequest(wakeRequest), .busAddr(busAddr), .busWdata(busWdata), .busRdata(busRdata),
   .timerIrqVector(timerIrqVector));

// ==== verification/tb.sv ====
// Purpose: random and corner tests of pdt_timer
// Assumes: clk 50 MHz, nrst low 8 cycles
// Notes:   sweep bounds allow free divider phase
`timescale 1ns/1ps
module tb;
   logic        clk, nrst, busWrite, busRead, timerIrq, wakeRequest;
   logic [7:0]  busAddr, busWdata, busRdata, d;
   logic [1:0]  timerIrqVector;
   logic [31:0] lfsr;
   int          failures, n_tests, n;
   pdt_timer u_dut (.clk(clk), .nrst(nrst), .busAddr(busAddr), .busWrite(busWrite), .busRead(busRead),
      .busWdata(busWdata), .busRdata(busRdata), .timerIrq(timerIrq), .timerIrqVector(timerIrqVector),
      .wakeRequest(wakeRequest));
   // ****
   // helpers
   // ****
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   function automatic logic [31:0] step(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic end_sim();
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(string s, logic [7:0] e, g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s exp %h got %h", s, e, g);
      end
   endtask
   // one-cycle strobe; read data settles just after the strobe edge
   task automatic bus(logic w, logic [7:0] a, v);
      @(posedge clk);
      {busAddr, busWdata, busWrite, busRead} <= {a, v, w, !w};
      @(posedge clk);
      {busWrite, busRead} <= 2'b00;
      #1 d = busRdata;
   endtask
   task automatic rc(logic [7:0] a, e);
      bus(1'b0, a, 8'h00);
      chk("read", e, d);
   endtask
   initial begin
      {nrst, busWrite, busRead, busAddr, busWdata, failures, n_tests} = '0;
      lfsr = 32'h1165;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      rc(8'hd3, 8'hff);
      rc(8'hd2, 8'h7f);
      rc(8'hd4, 8'h00);
      for (int i = 0; i < 6; i++) begin
         lfsr = step(lfsr);
         bus(1'b1, 8'hd3, lfsr[7:0]);
         rc(8'hd3, lfsr[7:0]);
         bus(1'b1, 8'hd2, lfsr[15:8]);
         rc(8'hd2, 8'h7f);
         rc({1'b0, lfsr[22:16]}, 8'h00);
      end
      $display("done stopped");
      bus(1'b1, 8'hd4, 8'h40);
      bus(1'b1, 8'hd3, 8'h00);
      rc(8'hd4, 8'hc0);
      chk("irq", 8'h01, {7'h0, timerIrq});
      bus(1'b1, 8'hd4, 8'h40);
      rc(8'hd4, 8'h40);
      bus(1'b1, 8'hd4, 8'ha0);
      rc(8'hd4, 8'h80);
      $display("done flag");
      // two ticks per tap; a hang shows as an out-of-range span
      for (int t = 0; t < 8; t++) begin
         bus(1'b1, 8'hd4, 8'h00);
         bus(1'b1, 8'hd3, 8'h02);
         bus(1'b1, 8'hd4, 8'h58 | 8'(t));
         for (n = 0; n < 4000 && timerIrq !== 1'b1; n++)
            @(posedge clk);
         chk("span", 8'h01, {7'h0, n > (24 << t) - 16 && n <= (24 << t) + 16});
         if (n == 4000) end_sim();
         if (t == 0) begin
            rc(8'hd3, 8'h00);
            repeat (12) @(posedge clk);
            rc(8'hd3, 8'hff);
         end
      end
      lfsr = step(lfsr);
      bus(1'b1, 8'hd2, {1'b0, lfsr[6:0]});
      bus(1'b0, 8'hd2, 8'h00);
      chk("psc", {1'b0, lfsr[6:0]}, d === {1'b0, 7'(lfsr[6:0] - 7'h01)} ? {1'b0, lfsr[6:0]} : d);
      $display("done running");
      end_sim();
   end
endmodule
